// ---- hp_ctrl_pkg.sv ----
// constants, register map and state encoding for the headphone control port
package hp_ctrl_pkg;

  // bus addressing
  localparam logic [6:0] SLAVE_ADDR    = 7'h60;
  localparam logic [7:0] GC_ADDR       = 8'h00;
  localparam logic [7:0] GC_RESET_CMD  = 8'h06;
  localparam logic       DIR_READ      = 1'h1;

  // register locations (pointer low three bits)
  localparam logic [2:0] PTR_RSVD0     = 3'h0;
  localparam logic [2:0] PTR_CHAN      = 3'h1;
  localparam logic [2:0] PTR_VOLUME    = 3'h2;
  localparam logic [2:0] PTR_FLOAT     = 3'h3;
  localparam logic [2:0] PTR_IDENT     = 3'h4;
  localparam logic [2:0] PTR_RSVD5     = 3'h5;
  localparam logic [2:0] PTR_TEST      = 3'h6;
  localparam logic [2:0] PTR_RSVD7     = 3'h7;
  localparam logic [2:0] PTR_RST       = 3'h0;

  // channel_enable_and_shutdown fields
  localparam int CHAN_EN_L_BIT         = 7;
  localparam int CHAN_EN_R_BIT         = 6;
  localparam int CHAN_THERMAL_BIT      = 1;
  localparam int CHAN_SHUTDOWN_BIT     = 0;
  localparam logic [7:0] CHAN_RST      = 8'h00;

  // volume_and_mute fields
  localparam int VOL_LEFT_SILENCE_BIT  = 7;
  localparam int VOL_RIGHT_SILENCE_BIT = 6;
  localparam int VOL_CODE_MSB          = 5;
  localparam int VOL_CODE_LSB          = 1;
  localparam logic [7:0] VOL_RST       = 8'hC0;

  // output_float_control fields
  localparam int FLOAT_L_BIT           = 1;
  localparam int FLOAT_R_BIT           = 0;
  localparam logic [7:0] FLOAT_RST     = 8'h00;

  // chip_identification; supplier value is arbitrary
  localparam logic [1:0] ID_SUPPLIER   = 2'h1;
  localparam logic [3:0] ID_VERSION    = 4'h0;

  localparam logic [7:0] TEST_RST      = 8'h00;

  // gain ramp timing
  localparam int CLK_PERIOD_NS         = 20;
  localparam int STEP_TIME_US          = 1000;
  localparam int STEP_CYCLES           = STEP_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WRITE = 3'b010,
    ST_ACK   = 3'b011,
    ST_READ  = 3'b100,
    ST_MACK  = 3'b101
  } port_state_e;

  function automatic logic is_reserved(input logic [2:0] ptr);
    is_reserved = (ptr == PTR_RSVD0) || (ptr == PTR_RSVD5) || (ptr == PTR_RSVD7);
  endfunction

endpackage

// ---- gain_ramp.sv ----
// steps two applied gain codes toward their targets, one code per tick
`timescale 1ns/1ps
`default_nettype none
module gain_ramp
  import hp_ctrl_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] target_l_i,
  input  wire logic [4:0] target_r_i,
  output logic      [4:0] gain_l_o,
  output logic      [4:0] gain_r_o
);
  localparam int CW = $clog2(STEP_LEN + 1);

  logic [CW-1:0] tick_cnt_reg;
  logic          tick;
  logic [4:0]    gain_reg [2];
  logic [4:0]    target   [2];

  assign target[0] = target_l_i;
  assign target[1] = target_r_i;
  assign tick      = (tick_cnt_reg == CW'(STEP_LEN - 1));
  assign gain_l_o  = gain_reg[0];
  assign gain_r_o  = gain_reg[1];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + CW'(1);
    end
  end

  // one step per tick toward target
  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        gain_reg[i] <= 5'h00;
      end else if (tick && gain_reg[i] < target[i]) begin
        gain_reg[i] <= gain_reg[i] + 5'h01;
      end else if (tick && gain_reg[i] > target[i]) begin
        gain_reg[i] <= gain_reg[i] - 5'h01;
      end
    end
  end

  sequence s_tick_up_l;
    tick && (gain_l_o < target_l_i);
  endsequence

  a_ramp_hold_between: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !tick |=> $stable(gain_l_o) && $stable(gain_r_o))
    else $error("gain moved between ticks");

  a_ramp_step_up: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_tick_up_l |=> gain_l_o == $past(gain_l_o) + 5'h01)
    else $error("left gain did not step up by one");

  a_ramp_tick_period: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tick |=> !tick)
    else $error("tick came twice in a row");

endmodule
`default_nettype wire

// ---- hp_ctrl_port.sv ----
// two-wire serial slave control port of the stereo headphone amplifier
//
// Operation
// - answer slave address 1100000 plus direction
// - address lsb one reads, zero writes
// - general call then 06h, both acknowledged
// - reset command restores all registers and volume
// - first written byte loads the pointer
// - pointer low three bits select register
// - upper five pointer bits are ignored
// - locations 00, 05, 07 are not acknowledged
// - location 01 enables, thermal, software shutdown
// - location 02 volume and two mutes
// - location 03 left and right float controls
// - location 04 read-only identification and version
// - location 06 read/write factory test register
// - gain ramps one step per millisecond
// - mutes bits 7,6, code bits 5:1
`timescale 1ns/1ps
`default_nettype none
module hp_ctrl_port
  import hp_ctrl_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       thermal_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  output logic            left_enable_o,
  output logic            right_enable_o,
  output logic            shutdown_o,
  output logic            left_silence_o,
  output logic            right_silence_o,
  output logic            left_float_o,
  output logic            right_float_o,
  output logic      [7:0] factory_test_o,
  output logic      [4:0] left_gain_o,
  output logic      [4:0] right_gain_o
);

  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic [2:0]  therm_sync_reg;
  logic        scl_reg;
  logic        sda_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        thermal_reg;
  logic        sda_low_reg;

  port_state_e state_reg;
  port_state_e after_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic        ack_on_reg;
  logic        ack_pend_reg;
  logic        gc_reg;
  logic        gc_cmd_reg;
  logic        ptr_pend_reg;
  logic        drive_n_reg;
  logic [2:0]  ptr_reg;

  logic [7:0]  chan_reg;
  logic [7:0]  vol_reg;
  logic [7:0]  float_reg;
  logic [7:0]  test_reg;

  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        addr_gc;
  logic        addr_me;
  logic        wr_ack;
  logic        ptr_load;
  logic        wr_commit;
  logic        soft_rst;
  logic        any_rst;
  logic [7:0]  rdata;
  logic [4:0]  target_l;
  logic [4:0]  target_r;

  function automatic logic [7:0] read_mux(input logic [2:0] ptr, input logic [7:0] chan,
                                          input logic [7:0] vol, input logic [7:0] flt,
                                          input logic [7:0] tst);
    case (ptr)
      PTR_CHAN:   read_mux = chan;
      PTR_VOLUME: read_mux = vol;
      PTR_FLOAT:  read_mux = flt;
      PTR_IDENT:  read_mux = {ID_SUPPLIER, 2'h0, ID_VERSION};
      PTR_TEST:   read_mux = tst;
      default:    read_mux = 8'h00;
    endcase
  endfunction

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_sync_reg   <= 3'h7;
      sda_sync_reg   <= 3'h7;
      therm_sync_reg <= 3'h0;
      scl_reg        <= 1'h1;
      sda_reg        <= 1'h1;
      thermal_reg    <= 1'h0;
      scl_prev_reg   <= 1'h1;
      sda_prev_reg   <= 1'h1;
    end else begin
      scl_sync_reg   <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg   <= {sda_sync_reg[1:0], sda_i};
      therm_sync_reg <= {therm_sync_reg[1:0], thermal_i};
      if (scl_sync_reg[2] == scl_sync_reg[1]) begin
        scl_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[2] == sda_sync_reg[1]) begin
        sda_reg <= sda_sync_reg[2];
      end
      if (therm_sync_reg[2] == therm_sync_reg[1]) begin
        thermal_reg <= therm_sync_reg[2];
      end
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  assign scl_rise   = scl_reg && !scl_prev_reg;
  assign scl_fall   = !scl_reg && scl_prev_reg;
  assign start_cond = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
  assign stop_cond  = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;
  assign rx_byte    = {shift_reg[6:0], sda_reg};
  assign byte_done  = scl_rise && (bit_cnt_reg == 3'h7);
  assign addr_gc    = (rx_byte == GC_ADDR);
  assign addr_me    = (rx_byte[7:1] == SLAVE_ADDR);
  assign wr_ack     = gc_reg ? (rx_byte == GC_RESET_CMD)
                    : (ptr_pend_reg || !is_reserved(ptr_reg));
  assign ptr_load   = (state_reg == ST_WRITE) && byte_done && !gc_reg && ptr_pend_reg;
  assign wr_commit  = (state_reg == ST_WRITE) && byte_done && !gc_reg && !ptr_pend_reg
                    && !is_reserved(ptr_reg);
  assign soft_rst   = (state_reg == ST_ACK) && scl_fall && ack_on_reg && gc_cmd_reg
                    && ack_pend_reg;
  assign any_rst    = rst_i || soft_rst;
  assign rdata      = read_mux(ptr_reg, chan_reg, vol_reg, float_reg, test_reg);

  // serial protocol engine
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      state_reg    <= ST_IDLE;
      after_reg    <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      ack_on_reg   <= 1'h0;
      ack_pend_reg <= 1'h0;
      gc_reg       <= 1'h0;
      gc_cmd_reg   <= 1'h0;
      ptr_pend_reg <= 1'h0;
      drive_n_reg  <= 1'h1;
    end else if (start_cond) begin
      state_reg    <= ST_ADDR;
      bit_cnt_reg  <= 3'h0;
      ack_on_reg   <= 1'h0;
      gc_reg       <= 1'h0;
      gc_cmd_reg   <= 1'h0;
      ptr_pend_reg <= 1'h0;
      drive_n_reg  <= 1'h1;
    end else if (stop_cond) begin
      state_reg   <= ST_IDLE;
      drive_n_reg <= 1'h1;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
          if (byte_done) begin
            state_reg <= ST_ACK;
            if (addr_gc) begin
              ack_pend_reg <= 1'h1;
              gc_reg       <= 1'h1;
              after_reg    <= ST_WRITE;
            end else if (addr_me && rx_byte[0] != DIR_READ) begin
              ack_pend_reg <= 1'h1;
              ptr_pend_reg <= 1'h1;
              after_reg    <= ST_WRITE;
            end else if (addr_me) begin
              ack_pend_reg <= !is_reserved(ptr_reg);
              after_reg    <= ST_READ;
            end else begin
              ack_pend_reg <= 1'h0;
              after_reg    <= ST_IDLE;
            end
          end
        end
        ST_WRITE: begin
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
          end
          if (byte_done) begin
            state_reg    <= ST_ACK;
            ack_pend_reg <= wr_ack;
            gc_cmd_reg   <= gc_reg;
            ptr_pend_reg <= 1'h0;
          end
        end
        ST_ACK: begin
          if (scl_fall && !ack_on_reg) begin
            drive_n_reg <= !ack_pend_reg;
            ack_on_reg  <= 1'h1;
          end else if (scl_fall) begin
            ack_on_reg  <= 1'h0;
            bit_cnt_reg <= 3'h0;
            if (!ack_pend_reg) begin
              drive_n_reg <= 1'h1;
              state_reg   <= ST_IDLE;
            end else if (after_reg == ST_READ) begin
              tx_reg      <= rdata;
              drive_n_reg <= rdata[7];
              state_reg   <= ST_READ;
            end else begin
              drive_n_reg <= 1'h1;
              state_reg   <= after_reg;
            end
          end
        end
        ST_READ: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_reg  <= ST_MACK;
              ack_on_reg <= 1'h0;
            end
          end
          if (scl_fall) begin
            tx_reg      <= {tx_reg[6:0], 1'h0};
            drive_n_reg <= tx_reg[6];
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              ack_on_reg <= 1'h1;
            end
          end
          if (scl_fall && ack_on_reg) begin
            tx_reg      <= rdata;
            drive_n_reg <= rdata[7];
            bit_cnt_reg <= 3'h0;
            ack_on_reg  <= 1'h0;
            state_reg   <= ST_READ;
          end else if (scl_fall) begin
            drive_n_reg <= 1'h1;
          end
        end
        default: begin
          state_reg   <= ST_IDLE;
          drive_n_reg <= 1'h1;
        end
      endcase
    end
  end

  // pointer survives stop and repeated start
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      ptr_reg <= PTR_RST;
    end else if (ptr_load) begin
      ptr_reg <= rx_byte[2:0];
    end
  end

  // register file
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      chan_reg  <= CHAN_RST;
      vol_reg   <= VOL_RST;
      float_reg <= FLOAT_RST;
      test_reg  <= TEST_RST;
    end else begin
      chan_reg[CHAN_THERMAL_BIT] <= thermal_reg;
      if (wr_commit) begin
        case (ptr_reg)
          PTR_CHAN: begin
            chan_reg[CHAN_EN_L_BIT]     <= rx_byte[CHAN_EN_L_BIT];
            chan_reg[CHAN_EN_R_BIT]     <= rx_byte[CHAN_EN_R_BIT];
            chan_reg[CHAN_SHUTDOWN_BIT] <= rx_byte[CHAN_SHUTDOWN_BIT];
          end
          PTR_VOLUME: begin
            vol_reg[7:VOL_CODE_LSB] <= rx_byte[7:VOL_CODE_LSB];
          end
          PTR_FLOAT: begin
            float_reg[FLOAT_L_BIT] <= rx_byte[FLOAT_L_BIT];
            float_reg[FLOAT_R_BIT] <= rx_byte[FLOAT_R_BIT];
          end
          PTR_TEST: begin
            test_reg <= rx_byte;
          end
          default: begin
            test_reg <= test_reg;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    sda_low_reg <= 1'h0;
  end

  assign target_l = vol_reg[VOL_LEFT_SILENCE_BIT] ? 5'h00
                  : vol_reg[VOL_CODE_MSB:VOL_CODE_LSB];
  assign target_r = vol_reg[VOL_RIGHT_SILENCE_BIT] ? 5'h00
                  : vol_reg[VOL_CODE_MSB:VOL_CODE_LSB];

  gain_ramp #(
    .STEP_LEN (STEP_LEN)
  ) u_ramp (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (any_rst),
    .target_l_i (target_l),
    .target_r_i (target_r),
    .gain_l_o   (left_gain_o),
    .gain_r_o   (right_gain_o)
  );

  assign sda_o           = sda_low_reg;
  assign sda_oe_n_o      = drive_n_reg;
  assign left_enable_o   = chan_reg[CHAN_EN_L_BIT];
  assign right_enable_o  = chan_reg[CHAN_EN_R_BIT];
  assign shutdown_o      = chan_reg[CHAN_SHUTDOWN_BIT];
  assign left_silence_o  = vol_reg[VOL_LEFT_SILENCE_BIT];
  assign right_silence_o = vol_reg[VOL_RIGHT_SILENCE_BIT];
  assign left_float_o    = float_reg[FLOAT_L_BIT];
  assign right_float_o   = float_reg[FLOAT_R_BIT];
  assign factory_test_o  = test_reg;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_addr_write_hit;
    (state_reg == ST_ADDR) && byte_done && addr_me && !rx_byte[0] && !start_cond
    && !stop_cond;
  endsequence

  sequence s_ack_driven;
    (state_reg == ST_ACK) && ack_on_reg && !sda_oe_n_o;
  endsequence

  a_addr_match_ack: assert property (s_addr_write_hit |=>
    state_reg == ST_ACK && ack_pend_reg && ptr_pend_reg && after_reg == ST_WRITE)
    else $error("own write address not acknowledged");

  a_dir_read_sel: assert property ((state_reg == ST_ADDR) && byte_done && addr_me
    && rx_byte[0] && !start_cond && !stop_cond |=> after_reg == ST_READ)
    else $error("read direction not selected");

  a_gc_restore: assert property (soft_rst |=>
    vol_reg == VOL_RST && test_reg == TEST_RST && ptr_reg == PTR_RST && state_reg == ST_IDLE)
    else $error("general call reset left state behind");

  a_ptr_low_bits: assert property (ptr_load && !soft_rst |=>
    ptr_reg == $past(rx_byte[2:0]))
    else $error("pointer not loaded from low three bits");

  a_ptr_kept: assert property (!ptr_load && !soft_rst |=> $stable(ptr_reg))
    else $error("pointer changed without a pointer byte");

  a_rsvd_nack: assert property ((state_reg == ST_WRITE) && byte_done && !gc_reg
    && !ptr_pend_reg && is_reserved(ptr_reg) && !start_cond && !stop_cond |=> !ack_pend_reg)
    else $error("reserved location acknowledged");

  a_ident_ro: assert property (wr_commit && ptr_reg == PTR_IDENT |=>
    $stable(chan_reg[7:6]) && $stable(vol_reg) && $stable(float_reg) && $stable(test_reg))
    else $error("write to identification changed a register");

  a_ack_release: assert property (s_ack_driven ##0 scl_fall |=>
    sda_oe_n_o == !(state_reg == ST_READ && !tx_reg[7]))
    else $error("acknowledge not released on next falling clock");

  a_mute_bits: assert property (wr_commit && ptr_reg == PTR_VOLUME |=>
    left_silence_o == $past(rx_byte[7]) && right_silence_o == $past(rx_byte[6])
    && vol_reg[0] == 1'h0)
    else $error("mute bits not taken from bits 7 and 6");

endmodule
`default_nettype wire

// ---- serial_master.sv ----
// two-wire bus master model facing the control port
`timescale 1ns/1ps
`default_nettype none
module serial_master (
  input  wire logic ref_clk_i,
  input  wire logic sda_oe_n_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic drive_low = 1'b0;
  int   slow      = 0;

  // pulled-up wire: low while either party pulls
  assign sda_o = !(drive_low || !sda_oe_n_i);
  initial scl_o = 1'b1;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  // start or repeated start, address byte follows
  task automatic start_cond();
    wait_clk(5);
    drive_low = 1'b0;
    wait_clk(5 + slow);
    scl_o = 1'b1;
    wait_clk(10);
    drive_low = 1'b1;
    wait_clk(10);
    scl_o = 1'b0;
  endtask

  task automatic stop_cond();
    wait_clk(5);
    drive_low = 1'b1;
    wait_clk(5 + slow);
    scl_o = 1'b1;
    wait_clk(10);
    drive_low = 1'b0;
    wait_clk(10);
  endtask

  // data set mid-low, wire sampled mid-high
  task automatic put_bit(input logic b, output logic seen);
    wait_clk(5 + slow);
    drive_low = !b;
    wait_clk(5);
    scl_o = 1'b1;
    wait_clk(5);
    seen = sda_o;
    wait_clk(5);
    scl_o = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask

  // last high ends the read with a not-acknowledge
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(last, s);
  endtask
endmodule
`default_nettype wire

// ---- headphone_amp_i2c_control_port_tb_top.sv ----
// self-checking bench for the headphone control port
`timescale 1ns/1ps
`default_nettype none
module headphone_amp_i2c_control_port_tb_top;
  import hp_ctrl_pkg::*;
  localparam int STEP = 8;
  logic       ref_clk_i, rst_i, thermal_i, scl, sda, oe_n;
  logic       le, re, sd, lsl, rsl, lfl, rfl, sda_drv;
  logic [7:0] ft;
  logic [4:0] gl, gr, g_prev;
  int         g_cnt = 0;
  int         fails = 0;
  int         samples_checked = 0;
  logic [7:0] regs [8];
  logic [2:0] cur_ptr;

  hp_ctrl_port #(.STEP_LEN(STEP)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .thermal_i(thermal_i),
    .sda_o(sda_drv), .sda_oe_n_o(oe_n), .left_enable_o(le), .right_enable_o(re), .shutdown_o(sd),
    .left_silence_o(lsl), .right_silence_o(rsl), .left_float_o(lfl), .right_float_o(rfl),
    .factory_test_o(ft), .left_gain_o(gl), .right_gain_o(gr));

  serial_master i_master (.ref_clk_i(ref_clk_i), .sda_oe_n_i(oe_n), .scl_o(scl), .sda_o(sda));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic usable(input logic [2:0] p);
    usable = !(p == 3'h0 || p == 3'h5 || p == 3'h7);
  endfunction

  function automatic logic [7:0] exp_rd(input logic [2:0] p);
    case (p)
      3'h1: exp_rd = {regs[1][7:6], 4'h0, thermal_i, regs[1][0]};
      3'h4: exp_rd = {ID_SUPPLIER, 2'h0, ID_VERSION};
      default: exp_rd = regs[p];
    endcase
  endfunction

  task automatic model_reset();
    regs = '{8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    cur_ptr = 3'h0;
  endtask

  task automatic check_outs();
    logic [7:0] e;
    e = {1'b0, regs[1][7:6], regs[1][0], regs[2][7:6], regs[3][1:0]};
    chk("control outputs", e, {1'b0, le, re, sd, lsl, rsl, lfl, rfl});
    chk("factory test", regs[6], ft);
    chk("sda drive level", 8'h00, {7'h0, sda_drv});
  endtask

  task automatic check_gain();
    repeat (34 * STEP) @(posedge ref_clk_i);
    #1;
    chk("left gain", {3'h0, regs[2][7] ? 5'h00 : regs[2][5:1]}, {3'h0, gl});
    chk("right gain", {3'h0, regs[2][6] ? 5'h00 : regs[2][5:1]}, {3'h0, gr});
  endtask

  task automatic xfer_write(input logic [7:0] ptr, input logic [7:0] d);
    logic a;
    i_master.start_cond();
    i_master.send_byte({SLAVE_ADDR, 1'b0}, a);
    chk("write address ack", 8'h01, {7'h0, a});
    i_master.send_byte(ptr, a);
    chk("pointer ack", 8'h01, {7'h0, a});
    cur_ptr = ptr[2:0];
    i_master.send_byte(d, a);
    chk("data ack", {7'h0, usable(cur_ptr)}, {7'h0, a});
    i_master.stop_cond();
    case (cur_ptr)
      3'h1: regs[1] = d & 8'hC1;
      3'h2: regs[2] = d & 8'hFE;
      3'h3: regs[3] = d & 8'h03;
      3'h6: regs[6] = d;
      default: ;
    endcase
    check_outs();
  endtask

  // two bytes from one location: no auto-increment
  task automatic xfer_read();
    logic       a;
    logic [7:0] b;
    thermal_i = 1'($urandom);
    i_master.start_cond();
    i_master.send_byte({SLAVE_ADDR, DIR_READ}, a);
    chk("read address ack", {7'h0, usable(cur_ptr)}, {7'h0, a});
    if (a) begin
      for (int k = 0; k < 2; k++) begin
        i_master.get_byte(k == 1, b);
        chk("read data", exp_rd(cur_ptr), b);
      end
    end
    i_master.stop_cond();
  endtask

  // pointer write, then repeated start into a read
  task automatic ptr_read(input logic [7:0] ptr);
    logic a;
    i_master.start_cond();
    i_master.send_byte({SLAVE_ADDR, 1'b0}, a);
    i_master.send_byte(ptr, a);
    chk("pointer ack", 8'h01, {7'h0, a});
    cur_ptr = ptr[2:0];
    xfer_read();
  endtask

  task automatic gen_call(input logic [7:0] cmd, input logic ok);
    logic a;
    i_master.start_cond();
    i_master.send_byte(GC_ADDR, a);
    chk("general call ack", 8'h01, {7'h0, a});
    i_master.send_byte(cmd, a);
    chk("command ack", {7'h0, ok}, {7'h0, a});
    i_master.stop_cond();
  endtask

  // applied left gain moves one code at a time, no faster than one per step
  always @(posedge ref_clk_i) begin
    g_cnt <= (gl === g_prev) ? g_cnt + 1 : 0;
    g_prev <= gl;
    if (!rst_i && gl !== g_prev && gl !== 5'h00) begin
      samples_checked++;
      if (g_cnt < STEP - 1
          || (gl !== 5'(g_prev + 5'h01) && 5'(gl + 5'h01) !== g_prev)) begin
        fails++;
        $display("BAD gain step expected one code per %0d cycles seen %h", STEP, gl);
      end
    end
  end

  initial begin
    logic       a;
    logic [7:0] r;
    logic [2:0] ptrs [5];
    logic [2:0] rsv [3];
    ptrs = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h4};
    rsv = '{3'h0, 3'h5, 3'h7};
    rst_i = 1'b1;
    thermal_i = 1'b0;
    model_reset();
    void'($urandom(96));
    repeat (16) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    check_outs();
    check_gain();
    for (int n = 0; n < 2; n++) begin
      foreach (ptrs[k]) begin
        r = 8'($urandom);
        i_master.slow = $urandom_range(0, 6);
        xfer_write({r[7:3], ptrs[k]}, 8'($urandom));
        if (n == 0) xfer_read();
        else ptr_read({~r[7:3], ptrs[k]});
      end
    end
    foreach (rsv[k]) begin
      xfer_write({5'h1F, rsv[k]}, 8'hA5);
      xfer_read();
    end
    xfer_write(8'h02, 8'h3E);
    check_gain();
    xfer_write(8'h02, 8'h8A);
    check_gain();
    for (int b = 0; b < 7; b++) begin
      i_master.start_cond();
      i_master.send_byte({SLAVE_ADDR ^ (7'h01 << b), 1'b0}, a);
      chk("foreign address ack", 8'h00, {7'h0, a});
      i_master.stop_cond();
    end
    xfer_write(8'h01, 8'hC1);
    gen_call(8'h05, 1'b0);
    check_outs();
    gen_call(GC_RESET_CMD, 1'b1);
    model_reset();
    repeat (8) @(posedge ref_clk_i);
    #1;
    check_outs();
    check_gain();
    xfer_read();
    test_done();
  end

  initial begin
    repeat (90000) @(posedge ref_clk_i);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
